//--- dv/lcd_ctrl_props.sv
// Purpose: port-level checks on the display controller
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound into every controller instance
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_props
    import lcd_ctrl_pkg::*;
#(
    parameter int N_SEG = 56,
    parameter int N_COM = 6
) (
    // clock and reset
    input wire logic               clk_i,
    input wire logic               rst_i,
    // bus and tick inputs
    input wire logic               cyc_i,
    input wire logic               stb_i,
    input wire logic               slow_tick_i,
    // observed outputs
    input wire logic               ack_o,
    input wire supply_s            supply_o,
    input wire logic               dac_power_o,
    input wire logic [4:0]         dac_code_o,
    input wire logic               bias_enable_o,
    input wire logic [2*N_COM-1:0] com_o,
    input wire logic [2*N_SEG-1:0] seg_o,
    input wire logic [N_SEG-1:0]   pin_is_display_o
);
    logic [2*N_SEG-1:0] map2; // display flag spread over rail bits
    // widen the per-pin flag to the 2-bit rail code
    always_comb begin
        for (int s = 0; s < N_SEG; s++) map2[2*s+:2] = {2{pin_is_display_o[s]}};
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after request");
    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ext_stands_alone: assert property (
        supply_o.ext |-> !supply_o.dac_en && !supply_o.boost)
        else $error("external supply with other enables");
    a_boost_needs_dac: assert property (
        supply_o.boost |-> supply_o.dac_en)
        else $error("boost without dac");
    a_ext_mutes_dac: assert property (
        supply_o.ext |-> !dac_power_o && dac_code_o == 5'h0)
        else $error("dac active under external supply");
    a_dac_code_live: assert property (
        dac_power_o |-> dac_code_o != 5'h0 && supply_o.dac_en)
        else $error("dac powered with zero code");
    a_off_commons_gnd: assert property (
        !bias_enable_o |-> com_o == '0)
        else $error("commons driven while disabled");
    a_off_pins_gnd: assert property (
        !bias_enable_o |-> (seg_o & map2) == '0)
        else $error("mapped pin driven while disabled");
    a_commons_on_step: assert property (
        !$stable(com_o) |-> $rose(ack_o) || $past(slow_tick_i) || $past(rst_i))
        else $error("commons moved without write or tick");
    c_ext: cover property (supply_o.ext);
    c_enable: cover property ($rose(bias_enable_o));
    c_ack_disabled: cover property (ack_o && !bias_enable_o);
endmodule : lcd_ctrl_props
bind lcd_segment_driver_control lcd_ctrl_props #(
    .N_SEG(N_SEG), .N_COM(N_COM)
) i_lcd_ctrl_props (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .slow_tick_i(slow_tick_i), .ack_o(ack_o), .supply_o(supply_o),
    .dac_power_o(dac_power_o), .dac_code_o(dac_code_o),
    .bias_enable_o(bias_enable_o), .com_o(com_o), .seg_o(seg_o),
    .pin_is_display_o(pin_is_display_o)
);
`default_nettype wire

//--- dv/lcd_panel_model.sv
// Purpose: passive panel seen through its first common line
// Assumes: rail codes 0 and 3 are the two full-swing levels
// Notes:   a pixel is lit only under full swing against common 0
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model #(
    parameter int N_SEG = 56
) (
    // drive from the controller
    input wire logic [11:0]        com_i,
    input wire logic [2*N_SEG-1:0] seg_i,
    // pixel state on common 0
    output logic [N_SEG-1:0]       lit_o
);
    // full swing: opposite codes that are both rail ends
    always_comb begin
        for (int s = 0; s < N_SEG; s++)
            lit_o[s] = &(seg_i[2*s+:2] ^ com_i[1:0]) && ~^com_i[1:0];
    end
endmodule : lcd_panel_model
`default_nettype wire

//--- dv/tb.sv
// Purpose: self-checking bench for the display controller
// Assumes: slow tick every four clocks, short blink counts
// Notes:   read data is checked from a queue by the ack monitor
`timescale 1ns/1ps
`default_nettype none
module tb
    import lcd_ctrl_pkg::*;
;
    localparam int SLOW = 8, FAST = 4; // shortened blink counts
    logic clk_i = 0, rst_i = 1, por_i = 1, slow_tick_i = 0, pick = 0;
    logic cyc_i = 0, stb_i = 0, we_i = 0, ack_o, dac_power_o;
    logic supply_from_battery_o, bias_enable_o;
    logic [ADR_W-1:0] adr_i = '0;
    logic [3:0]       sel_i = 4'h1;
    logic [DAT_W-1:0] dat_i = '0, dat_o;
    supply_s          supply_o;
    logic [4:0]       dac_code_o, code;
    logic [11:0]      com_o;
    logic [111:0]     seg_o;
    logic [55:0]      pin_is_display_o, lit;
    logic [1:0]       tdiv = '0;
    logic [31:0]      seed = 32'he5d7, q[$];
    logic [13:0]      ixs[6] = '{IDX_CTRL, IDX_BLK23, IDX_BLK22,
                                 IDX_FORCE, IDX_DAC, 14'h2500};
    int               mismatches = 0, checked = 0, n;
    wire [11:0]       w = pick ? {11'h0, lit[BLINK_A]} : com_o;
    lcd_segment_driver_control #(
        .BLINK_SLOW_CNT(SLOW), .BLINK_FAST_CNT(FAST)
    ) i_lcd_segment_driver_control (
        .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
        .slow_tick_i(slow_tick_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .supply_o(supply_o),
        .supply_from_battery_o(supply_from_battery_o),
        .dac_power_o(dac_power_o), .dac_code_o(dac_code_o),
        .bias_enable_o(bias_enable_o), .com_o(com_o), .seg_o(seg_o),
        .pin_is_display_o(pin_is_display_o)
    );
    lcd_panel_model i_lcd_panel_model (
        .com_i(com_o), .seg_i(seg_o), .lit_o(lit)
    );
    always #12.5 clk_i = ~clk_i;
    // slow time base: one tick every four clocks
    always @(posedge clk_i) begin
        tdiv <= tdiv + 2'h1;
        slow_tick_i <= (tdiv == 2'h3);
    end
    // read monitor: oldest expectation against returned data
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) chk(dat_o, q.pop_front());
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    // one classic cycle; held until ack, then released
    task automatic wb(input logic wr, input logic [13:0] ix,
                      input logic [7:0] d);
        int t;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i} <= {2'b11, wr};
        adr_i <= {ix, 2'b00};
        dat_i <= {24'h0, d};
        t = 0;
        do begin @(posedge clk_i); t++; end while (ack_o !== 1'b1 && t < 20);
        if (t >= 20) begin mismatches++; report_and_stop(); end
        {cyc_i, stb_i} <= 2'b00;
        @(negedge clk_i);
    endtask : wb
    task automatic rd(input logic [13:0] ix, input logic [7:0] e);
        q.push_back({24'h0, e});
        wb(1'b0, ix, 8'h00);
    endtask : rd
    // ticks between two later changes of the watched value
    task automatic span(output int cnt);
        logic [11:0] v;
        for (int k = 0; k < 2; k++) begin
            v = w;
            cnt = 0;
            for (int t = 0; t < 4000 && w === v; t++) begin
                @(negedge clk_i);
                cnt += int'(slow_tick_i);
            end
            if (w === v) begin mismatches++; report_and_stop(); end
        end
    endtask : span
    initial begin
        repeat (90000) @(posedge clk_i);
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        {rst_i, por_i} <= 2'b00;
        foreach (ixs[i]) rd(ixs[i], 8'h00);
        chk(com_o, 12'h0);
        seed = xs(seed);
        code = seed[4:0] | 5'h01;
        wb(1'b1, IDX_DAC, {3'h0, code});
        for (int v = 0; v < 4; v++) begin
            wb(1'b1, IDX_BLK23, {v[1:0], 6'h00});
            chk(supply_o, v == 3 ? 3'h4 : v ? {2'b01, v[1]} : 3'h0);
            chk({dac_power_o, dac_code_o}, v % 3 ? {1'b1, code} : 6'h0);
        end
        wb(1'b1, IDX_BLK23, 8'h40);
        wb(1'b1, IDX_DAC, 8'h00);
        chk(dac_power_o, 1'b0);
        wb(1'b1, IDX_BLK22, 8'h80);
        chk(supply_from_battery_o, 1'b1);
        wb(1'b1, IDX_MAP0, 8'h01);
        wb(1'b1, IDX_SEG0, 8'h01);
        wb(1'b1, IDX_CTRL, 8'h80);
        chk(com_o[11:8], {2{LVL_HIGH}});
        for (int f = 0; f < 4; f++) begin
            wb(1'b1, IDX_FORCE, f[7:0]);
            chk(lit[0], f != 2);
        end
        rd(IDX_SEG0, 8'h01);
        wb(1'b1, IDX_SEG0 + 14'h1, 8'h3f);
        wb(1'b1, IDX_FORCE, 8'h04);
        wb(1'b1, IDX_FORCE, 8'h00);
        rd(IDX_SEG0, 8'h00);
        rd(IDX_SEG0 + 14'h1, 8'h3f);
        wb(1'b1, IDX_CTRL, 8'h00);
        chk({com_o, seg_o[3:0], bias_enable_o}, 17'h0);
        wb(1'b1, IDX_CTRL, 8'hd0);
        chk(pin_is_display_o[27:26], 2'h2);
        wb(1'b1, IDX_CTRL, 8'he0);
        chk(pin_is_display_o[27:26], 2'h3);
        wb(1'b1, IDX_SEG0 + 14'd27, 8'h3f);
        wb(1'b1, IDX_CTRL, 8'h88);
        chk(pin_is_display_o[27:26], 2'h0);
        wb(1'b1, IDX_MAP0 + 14'h3, 8'h0c);
        chk({pin_is_display_o[27:26], seg_o[55:54]}, 4'hc | com_o[9:8]);
        for (int m = 0; m < 8; m++) begin
            wb(1'b1, IDX_CTRL, {1'b1, m[2:0], 2'b00, m[1:0]});
            span(n);
            chk(n, 512 >> m[1:0]);
        end
        wb(1'b1, IDX_MAP0 + 14'h2, 8'h40);
        wb(1'b1, IDX_SEG0 + 14'd22, 8'h01);
        wb(1'b1, IDX_BLK22, 8'h01);
        pick = 1'b1;
        for (int r = 0; r < 2; r++) begin
            wb(1'b1, IDX_CTRL, {4'hc, 1'b0, r[0], 2'h0});
            span(n);
            chk(n, r ? FAST : SLOW);
        end
        @(posedge clk_i) rst_i <= 1'b1;
        @(posedge clk_i) rst_i <= 1'b0;
        rd(IDX_BLK22, 8'h01);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire

//--- hw/lcd_ctrl_pkg.sv
// Purpose: shared constants and types for the segment display controller
// Assumes: register index times four is the wishbone byte address
// Notes:   register data sits in the low byte of each word
package lcd_ctrl_pkg;

    // bus geometry
    localparam int          ADR_W       = 16;
    localparam int          IDX_W       = 14;
    localparam int          DAT_W       = 32;
    localparam int          REG_W       = 8;

    // register indices
    localparam logic [13:0] IDX_CTRL    = 14'h2400;
    localparam logic [13:0] IDX_BLK23   = 14'h2401;
    localparam logic [13:0] IDX_BLK22   = 14'h2402;
    localparam logic [13:0] IDX_MAP0    = 14'h2403;
    localparam logic [13:0] IDX_FORCE   = 14'h240c;
    localparam logic [13:0] IDX_DAC     = 14'h240d;
    localparam logic [13:0] IDX_STAT    = 14'h240e;
    localparam logic [13:0] IDX_SEG0    = 14'h2410;
    localparam int          MAP_REGS    = 7;

    // field positions
    localparam int          F_CLK       = 0;
    localparam int          F_BRATE     = 2;
    localparam int          F_ALLCOM    = 3;
    localparam int          F_MODE      = 4;
    localparam int          F_EN        = 7;
    localparam int          F_MASK      = 0;
    localparam int          F_VMODE     = 6;
    localparam int          F_BAT       = 7;
    localparam int          F_ON        = 0;
    localparam int          F_BLANK     = 1;
    localparam int          F_CLR       = 2;
    localparam int          F_PHASE     = 0;
    localparam int          F_POL       = 3;
    localparam int          F_BLINK     = 4;

    // pin geometry
    localparam int          PIX_W       = 6;
    localparam int          BLINK_A     = 22;
    localparam int          BLINK_B     = 23;
    localparam int          SHARED_A    = 26;
    localparam int          SHARED_B    = 27;

    // multiplex and bias codes
    localparam logic [2:0]  MODE_4_THIRD = 3'h0;
    localparam logic [2:0]  MODE_3_THIRD = 3'h1;
    localparam logic [2:0]  MODE_2_HALF  = 3'h2;
    localparam logic [2:0]  MODE_3_HALF  = 3'h3;
    localparam logic [2:0]  MODE_STATIC  = 3'h4;
    localparam logic [2:0]  MODE_5_THIRD = 3'h5;
    localparam logic [2:0]  MODE_6_THIRD = 3'h6;

    // supply generation codes
    localparam logic [1:0]  VM_EXT      = 2'h3;
    localparam logic [1:0]  VM_BOOST    = 2'h2;
    localparam logic [1:0]  VM_DAC      = 2'h1;

    // drive rails: ground, one third (or half), two thirds, full
    localparam logic [1:0]  LVL_GND     = 2'h0;
    localparam logic [1:0]  LVL_LOW     = 2'h1;
    localparam logic [1:0]  LVL_HIGH    = 2'h2;
    localparam logic [1:0]  LVL_TOP     = 2'h3;
    localparam logic [1:0]  LVL_MID     = 2'h1;

    // timing on the 32768 Hz tick
    localparam int          FW_HZ         = 32768;
    localparam int          DIV_MAX       = 512;
    localparam int          BLINK_SLOW_MS = 1000;
    localparam int          BLINK_FAST_MS = 500;
    localparam int          BLINK_SLOW_TICKS = FW_HZ * BLINK_SLOW_MS / 1000;
    localparam int          BLINK_FAST_TICKS = FW_HZ * BLINK_FAST_MS / 1000;

    // bias family
    typedef enum logic [1:0] {BIAS_THIRD, BIAS_HALF, BIAS_STATIC} bias_e;

    // decoded supply enables
    typedef struct packed {
        logic ext;
        logic dac_en;
        logic boost;
    } supply_s;

endpackage : lcd_ctrl_pkg

//--- hw/lcd_segment_driver_control.sv
// Purpose: control logic for a multiplexed segment display driver
// Assumes: slow_tick_i pulses once per 32768 Hz period, synchronous
// Notes:   pin drive is a 2-bit rail code; pads and analog are outside
// What this block does
// - decode supply field into three enables
// - external supply makes contrast code irrelevant
// - battery bit selects battery supply always
// - mode field picks phases and bias
// - five-phase mode converts pin 27, six-phase pins 27 and 26
// - all-common converts mapped pins 26, 27
// - force lit/dark; lit wins; data kept
// - clear bit zeroes mapped segment data
// - disabled: ground bias and mapped pins
// - frame clock divides by 512..64
// - unused commons carry segment-off waveform
// - pins 22, 23 blink at 0.5/1 Hz
// - six-bit blink masks, kept across power modes
// - zero contrast code bypasses the DAC
// - boost on only when the supply field selects boost
// - six commons, 56 segment pins
// - six data bits per pin, one per phase
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module lcd_segment_driver_control
    import lcd_ctrl_pkg::*;
#(
    parameter int N_SEG            = 56,
    parameter int N_COM            = 6,
    parameter int BLINK_SLOW_CNT   = BLINK_SLOW_TICKS,
    parameter int BLINK_FAST_CNT   = BLINK_FAST_TICKS
) (
    // clock and resets
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               por_i,
    // 32768 Hz time base
    input  wire logic               slow_tick_i,
    // wishbone slave
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [ADR_W-1:0]   adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [DAT_W-1:0]   dat_i,
    output logic      [DAT_W-1:0]   dat_o,
    output logic                    ack_o,
    // supply control
    output supply_s                 supply_o,
    output logic                    supply_from_battery_o,
    output logic                    dac_power_o,
    output logic      [4:0]         dac_code_o,
    output logic                    bias_enable_o,
    // pin drive
    output logic      [2*N_COM-1:0] com_o,
    output logic      [2*N_SEG-1:0] seg_o,
    output logic      [N_SEG-1:0]   pin_is_display_o
);

    // control registers
    logic [1:0]       frame_clock_select;   // divider code
    logic             blink_rate_select;    // 1: 1 Hz
    logic             force_commons_all;    // pins 26/27 as commons
    logic [2:0]       mux_bias_select;      // phases and bias
    logic             display_enable_bit;   // master enable
    logic [5:0]       blink_mask_pin23;     // blinking pixels, pin 23
    logic [5:0]       blink_mask_pin22;     // blinking pixels, pin 22
    logic [1:0]       supply_gen_select;    // supply generation
    logic             supply_from_battery;  // battery supply
    logic             force_all_lit;        // all segments on
    logic             force_all_dark;       // all segments off
    logic             clear_segment_data;   // wipes mapped data
    logic [4:0]       contrast_dac_code;    // contrast level
    logic [N_SEG-1:0] display_mapping_bit;  // 1: pin is display
    logic [PIX_W-1:0] segment_data_field [N_SEG]; // per-pin pixels

    // timing state
    logic [8:0]       div_cnt;              // frame divider
    logic             frame_tick;           // one frame-clock step
    logic [2:0]       phase;                // active common
    logic             pol;                  // frame polarity
    logic [15:0]      blink_cnt;            // blink half-period
    logic             blink_off;            // blinking pixels dark

    // bus decode
    logic [IDX_W-1:0] idx;                  // register index
    logic             req;                  // new access
    logic             wr;                   // write strobe, low lane
    logic [REG_W-1:0] wbyte;                // written byte
    logic [REG_W-1:0] rbyte;                // read byte
    logic [REG_W-1:0] next_rbyte;           // read mux
    logic             seg_hit;              // index in data window
    logic [13:0]      seg_off;              // offset into data window

    // mode decode
    logic [2:0]       nph;                  // active common count
    bias_e            bias;                 // bias family
    logic             conv_a;               // pin 26 is a common
    logic             conv_b;               // pin 27 is a common

    // rail codes
    logic [1:0]       lv_com_sel;           // selected common
    logic [1:0]       lv_com_uns;           // unselected common
    logic [1:0]       lv_seg_on;            // lit pixel
    logic [1:0]       lv_seg_off;           // dark pixel
    logic [1:0]       com_lvl [N_COM];      // per-common rail

    assign idx     = adr_i[ADR_W-1:2];
    assign req     = cyc_i & stb_i & ~ack_o;
    assign wr      = req & we_i & sel_i[0];
    assign wbyte   = dat_i[REG_W-1:0];
    assign seg_off = idx - IDX_SEG0;
    assign seg_hit = (idx >= IDX_SEG0) && (seg_off < 14'(N_SEG));

    // ack one cycle after the request, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // read mux; unmapped indices read zero
    always_comb begin
        next_rbyte = 8'h00;
        if (seg_hit) begin
            next_rbyte = {2'h0, segment_data_field[seg_off[5:0]]};
        end else if (idx >= IDX_MAP0 && idx < IDX_MAP0 + 14'(MAP_REGS)) begin
            next_rbyte = display_mapping_bit[8*(idx-IDX_MAP0) +: 8];
        end else begin
            case (idx)
                IDX_CTRL:  next_rbyte = {display_enable_bit, mux_bias_select,
                                         force_commons_all, blink_rate_select,
                                         frame_clock_select};
                IDX_BLK23: next_rbyte = {supply_gen_select, blink_mask_pin23};
                IDX_BLK22: next_rbyte = {supply_from_battery, 1'b0,
                                         blink_mask_pin22};
                IDX_FORCE: next_rbyte = {5'h00, clear_segment_data,
                                         force_all_dark, force_all_lit};
                IDX_DAC:   next_rbyte = {3'h0, contrast_dac_code};
                IDX_STAT:  next_rbyte = {3'h0, blink_off, pol, phase};
                default:   next_rbyte = 8'h00;
            endcase
        end
    end

    // read data captured with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rbyte <= 8'h00;
        end else if (req) begin
            rbyte <= next_rbyte;
        end
    end
    assign dat_o = {24'h000000, rbyte};

    // control register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_clock_select  <= 2'h0;
            blink_rate_select   <= 1'b0;
            force_commons_all   <= 1'b0;
            mux_bias_select     <= MODE_4_THIRD;
            display_enable_bit  <= 1'b0;
            supply_gen_select   <= 2'h0;
            supply_from_battery <= 1'b0;
            force_all_lit       <= 1'b0;
            force_all_dark      <= 1'b0;
            clear_segment_data  <= 1'b0;
            contrast_dac_code   <= 5'h00;
        end else if (wr) begin
            case (idx)
                IDX_CTRL: begin
                    frame_clock_select <= wbyte[F_CLK +: 2];
                    blink_rate_select  <= wbyte[F_BRATE];
                    force_commons_all  <= wbyte[F_ALLCOM];
                    mux_bias_select    <= wbyte[F_MODE +: 3];
                    display_enable_bit <= wbyte[F_EN];
                end
                IDX_BLK23: supply_gen_select <= wbyte[F_VMODE +: 2];
                IDX_BLK22: supply_from_battery <= wbyte[F_BAT];
                IDX_FORCE: begin
                    force_all_lit      <= wbyte[F_ON];
                    force_all_dark     <= wbyte[F_BLANK];
                    clear_segment_data <= wbyte[F_CLR];
                end
                IDX_DAC:   contrast_dac_code <= wbyte[4:0];
                default:   ;
            endcase
        end
    end

    // blink masks survive the ordinary reset; only power-on clears them
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            blink_mask_pin22 <= 6'h00;
            blink_mask_pin23 <= 6'h00;
        end else if (wr && idx == IDX_BLK23) begin
            blink_mask_pin23 <= wbyte[F_MASK +: PIX_W];
        end else if (wr && idx == IDX_BLK22) begin
            blink_mask_pin22 <= wbyte[F_MASK +: PIX_W];
        end
    end

    // pin mapping registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            display_mapping_bit <= '0;
        end else if (wr && idx >= IDX_MAP0 && idx < IDX_MAP0 + 14'(MAP_REGS)) begin
            display_mapping_bit[8*(idx-IDX_MAP0) +: 8] <= wbyte;
        end
    end

    // segment data; clear wipes mapped pins while the bit is set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int n = 0; n < N_SEG; n++) begin
                segment_data_field[n] <= '0;
            end
        end else begin
            for (int n = 0; n < N_SEG; n++) begin
                if (clear_segment_data && display_mapping_bit[n]) begin
                    segment_data_field[n] <= '0;
                end else if (wr && seg_hit && seg_off == 14'(n)) begin
                    segment_data_field[n] <= wbyte[PIX_W-1:0];
                end
            end
        end
    end

    // supply decode and contrast DAC gating
    always_comb begin
        supply_o.ext    = (supply_gen_select == VM_EXT);
        supply_o.dac_en = (supply_gen_select == VM_BOOST) ||
                          (supply_gen_select == VM_DAC);
        supply_o.boost  = (supply_gen_select == VM_BOOST);
    end
    assign supply_from_battery_o = supply_from_battery;
    assign dac_power_o = supply_o.dac_en && !supply_o.ext &&
                         (contrast_dac_code != 5'h00);
    assign dac_code_o  = dac_power_o ? contrast_dac_code : 5'h00;
    assign bias_enable_o = display_enable_bit;

    // mode decode: phase count and bias family
    always_comb begin
        case (mux_bias_select)
            MODE_4_THIRD: begin nph = 3'd4; bias = BIAS_THIRD; end
            MODE_3_THIRD: begin nph = 3'd3; bias = BIAS_THIRD; end
            MODE_2_HALF:  begin nph = 3'd2; bias = BIAS_HALF; end
            MODE_3_HALF:  begin nph = 3'd3; bias = BIAS_HALF; end
            MODE_STATIC:  begin nph = 3'd1; bias = BIAS_STATIC; end
            MODE_5_THIRD: begin nph = 3'd5; bias = BIAS_THIRD; end
            MODE_6_THIRD: begin nph = 3'd6; bias = BIAS_THIRD; end
            default:      begin nph = 3'd4; bias = BIAS_THIRD; end
        endcase
    end

    // shared pins turned into commons
    assign conv_b = (mux_bias_select == MODE_5_THIRD) ||
                    (mux_bias_select == MODE_6_THIRD) ||
                    (force_commons_all && display_mapping_bit[SHARED_B]);
    assign conv_a = (mux_bias_select == MODE_6_THIRD) ||
                    (force_commons_all && display_mapping_bit[SHARED_A]);

    // frame divider on the 32768 Hz tick
    assign frame_tick = slow_tick_i &&
        (div_cnt >= 9'((DIV_MAX >> frame_clock_select) - 1));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= 9'h000;
        end else if (frame_tick) begin
            div_cnt <= 9'h000;
        end else if (slow_tick_i) begin
            div_cnt <= div_cnt + 9'h001;
        end
    end

    // phase stepping and frame polarity
    always_ff @(posedge clk_i) begin
        if (rst_i || !display_enable_bit) begin
            phase <= 3'h0;
            pol   <= 1'b0;
        end else if (frame_tick) begin
            if (phase >= nph - 3'd1) begin
                phase <= 3'h0;
                pol   <= ~pol;
            end else begin
                phase <= phase + 3'h1;
            end
        end
    end

    // blink time base
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blink_cnt <= 16'h0000;
            blink_off <= 1'b0;
        end else if (slow_tick_i) begin
            if (blink_cnt >= 16'((blink_rate_select ? BLINK_FAST_CNT
                                                    : BLINK_SLOW_CNT) - 1)) begin
                blink_cnt <= 16'h0000;
                blink_off <= ~blink_off;
            end else begin
                blink_cnt <= blink_cnt + 16'h0001;
            end
        end
    end

    // rail codes for the present polarity and bias
    always_comb begin
        lv_com_sel = pol ? LVL_GND : LVL_TOP;
        lv_seg_on  = pol ? LVL_TOP : LVL_GND;
        case (bias)
            BIAS_THIRD: begin
                lv_com_uns = pol ? LVL_HIGH : LVL_LOW;
                lv_seg_off = pol ? LVL_LOW : LVL_HIGH;
            end
            BIAS_HALF: begin
                lv_com_uns = LVL_MID;
                lv_seg_off = lv_com_sel;
            end
            default: begin
                lv_com_uns = lv_com_sel;
                lv_seg_off = lv_com_sel;
            end
        endcase
    end

    // common lines; unused ones follow the dark-segment wave
    always_comb begin
        for (int c = 0; c < N_COM; c++) begin
            if (!display_enable_bit) begin
                com_lvl[c] = LVL_GND;
            end else if (3'(c) >= nph) begin
                com_lvl[c] = lv_seg_off;
            end else if (3'(c) == phase) begin
                com_lvl[c] = lv_com_sel;
            end else begin
                com_lvl[c] = lv_com_uns;
            end
            com_o[2*c +: 2] = com_lvl[c];
        end
    end

    // segment pins: pixel, blink, force, conversion and enable
    always_comb begin
        logic pix;
        pix = 1'b0;
        for (int n = 0; n < N_SEG; n++) begin
            pix = segment_data_field[n][phase];
            if (n == BLINK_A) begin
                pix = pix && !(blink_off && blink_mask_pin22[phase]);
            end
            if (n == BLINK_B) begin
                pix = pix && !(blink_off && blink_mask_pin23[phase]);
            end
            if (force_all_lit) begin
                pix = 1'b1;
            end else if (force_all_dark) begin
                pix = 1'b0;
            end
            if (n == SHARED_B && conv_b) begin
                seg_o[2*n +: 2] = com_lvl[4];
            end else if (n == SHARED_A && conv_a) begin
                seg_o[2*n +: 2] = com_lvl[5];
            end else if (!display_enable_bit && display_mapping_bit[n]) begin
                seg_o[2*n +: 2] = LVL_GND;
            end else begin
                seg_o[2*n +: 2] = pix ? lv_seg_on : lv_seg_off;
            end
            pin_is_display_o[n] = display_mapping_bit[n] ||
                                  (n == SHARED_A && conv_a) ||
                                  (n == SHARED_B && conv_b);
        end
    end

endmodule : lcd_segment_driver_control

`default_nettype wire
